// *** design/acrc_pkg.sv ***
/*
 * Constants, ratio table and helper functions for the audio clock ratio
 * control block. Assumes a single master timebase clock domain; every other
 * signal reaching the block except the ADC sample bit is resynchronised before use.
 */
// Functional notes
// - catch the serial-select level at the control reset rising edge.
// - control values pass two flip-flops into the timebase domain before use.
// - slave mode: both word frames and bit strobe are inputs.
// - master mode: both word frames and bit strobe are driven.
// - four DAC data inputs share one DAC frame; ADC has own frame.
// - ratios 128 to 768 fs; slave mode finds the ratio by itself.
// - slave mode: error beyond 32 clocks disables interface, holds last sample.
// - three-bit codes 000..101 select 128,192,256,384,512,768 fs.
// - codes 000 and 001 belong to the DAC path only.
// - ADC and DAC rates derive separately from the shared timebase.
// - 128fs oversampling, DAC 64fs when running at 128 or 192 fs.
// - ADC half-oversample bit moves ADC processing to 64fs.
// - master, codes 000/001, no DSP: bit strobe is timebase over two.
// - master, codes 010/011/100, no DSP: bit strobe is timebase over four.
// - master with DSP format: bit strobe runs at full timebase rate.
// - runs straight from the timebase pin, no setup needed.
// - role select: 0 slave, 1 master; slave after reset.
// - DSP formats put eight DAC channels on the first data input; the code samples all four inputs alike in every format.
package acrc_pkg;

   // ----------------------------------------------------------------
   // ratio codes
   // ----------------------------------------------------------------
   localparam logic [2:0] RATIO_128 = 3'h0;
   localparam logic [2:0] RATIO_192 = 3'h1;
   localparam logic [2:0] RATIO_256 = 3'h2;
   localparam logic [2:0] RATIO_384 = 3'h3;
   localparam logic [2:0] RATIO_512 = 3'h4;
   localparam logic [2:0] RATIO_768 = 3'h5;
   localparam logic [2:0] RATIO_LAST = 3'h5;
   localparam logic [2:0] ADC_RATIO_FALLBACK = 3'h2;

   // ----------------------------------------------------------------
   // cycle counts and reset values
   // ----------------------------------------------------------------
   localparam int CNT_W = 10;
   localparam logic [9:0] CYC_128 = 10'h080;
   localparam logic [9:0] CYC_192 = 10'h0c0;
   localparam logic [9:0] CYC_256 = 10'h100;
   localparam logic [9:0] CYC_384 = 10'h180;
   localparam logic [9:0] CYC_512 = 10'h200;
   localparam logic [9:0] CYC_768 = 10'h300;
   localparam logic [9:0] RATIO_TOL = 10'h020;
   localparam logic [9:0] CNT_MAX = 10'h3ff;
   localparam logic [2:0] RST_RATIO = 3'h2;
   localparam logic RST_ROLE = 1'b0;
   localparam logic RST_SPI = 1'b1;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [9:0] ratio_cycles(input logic [2:0] code);
      case (code)
         RATIO_128: ratio_cycles = CYC_128;
         RATIO_192: ratio_cycles = CYC_192;
         RATIO_256: ratio_cycles = CYC_256;
         RATIO_384: ratio_cycles = CYC_384;
         RATIO_512: ratio_cycles = CYC_512;
         default: ratio_cycles = CYC_768;
      endcase
   endfunction

   function automatic logic low_ratio(input logic [2:0] code);
      low_ratio = (code == RATIO_128) || (code == RATIO_192);
   endfunction

endpackage

// *** design/acrc_sync.sv ***
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit changes slowly compared with the sampling clock.
 */
`timescale 1ns/1ps
module acrc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] stage1_ff;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage1_ff <= RST_VAL;
         sync_o <= RST_VAL;
      end
      else
      begin
         stage1_ff <= async_i;
         sync_o <= stage1_ff;
      end
   end
endmodule // acrc_sync

// *** design/acrc_ratio_det.sv ***
/*
 * Measures timebase cycles between word-frame rising edges and maps the
 * period to a ratio code within the allowed tolerance.
 * Assumes frame_rise_i is a one-cycle pulse in the timebase domain.
 */
`timescale 1ns/1ps
module acrc_ratio_det #(
   parameter logic LOW_OK = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic frame_rise_i,
   output logic [2:0] code_o,
   output logic lock_o
);
   logic [9:0] cnt_ff;
   logic seen_ff;
   logic hit;
   logic [2:0] hit_code;
   logic [9:0] nom;

   // ----------------------------------------------------------------
   // nearest legal ratio within tolerance
   // ----------------------------------------------------------------
   always_comb
   begin
      nom = '0;
      hit = 1'b0;
      hit_code = acrc_pkg::RST_RATIO;
      for (int i = 0; i <= int'(acrc_pkg::RATIO_LAST); i++)
      begin
         nom = acrc_pkg::ratio_cycles(3'(i));
         if ((LOW_OK || !acrc_pkg::low_ratio(3'(i))) &&
             (cnt_ff + acrc_pkg::RATIO_TOL >= nom) &&
             (cnt_ff <= nom + acrc_pkg::RATIO_TOL))
         begin
            hit = 1'b1;
            hit_code = 3'(i);
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         cnt_ff <= '0;
      else if (frame_rise_i)
         cnt_ff <= 10'h001;
      else if (cnt_ff != acrc_pkg::CNT_MAX)
         cnt_ff <= cnt_ff + 10'h001;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         seen_ff <= 1'b0;
         code_o <= acrc_pkg::RST_RATIO;
         lock_o <= 1'b0;
      end
      else if (frame_rise_i)
      begin
         seen_ff <= 1'b1;
         lock_o <= seen_ff && hit;
         if (seen_ff && hit)
            code_o <= hit_code;
      end
      else if (cnt_ff == acrc_pkg::CNT_MAX)
         lock_o <= 1'b0;
   end
endmodule // acrc_ratio_det

// *** design/acrc_top.sv ***
/*
 * Audio clock ratio control: port-type latch, control resynchronisation,
 * slave ratio detection and checking, master frame and bit strobe
 * generation, oversampling selection and serial data sampling.
 * Assumes ref_clk_i is the master timebase; all pins are asynchronous and
 * pass through two flip-flops before use, except adc_sample_bit_i, which is sampled directly.
 */
`timescale 1ns/1ps
module acrc_top (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic control_reset_n_i,
   input wire logic serial_select_i,
   input wire logic master_slave_select_i,
   input wire logic [2:0] dac_ratio_field_i,
   input wire logic [2:0] adc_ratio_field_i,
   input wire logic dsp_format_i,
   input wire logic adc_half_oversample_i,
   input wire logic bit_strobe_i,
   input wire logic dac_word_frame_i,
   input wire logic adc_word_frame_i,
   input wire logic [3:0] dac_serial_inputs_i,
   input wire logic adc_sample_bit_i,
   output logic bit_strobe_o,
   output logic bit_strobe_oe_o,
   output logic bit_strobe_bypass_o,
   output logic dac_word_frame_o,
   output logic dac_word_frame_oe_o,
   output logic adc_word_frame_o,
   output logic adc_word_frame_oe_o,
   output logic adc_serial_data_o,
   output logic [3:0] dac_bits_o,
   output logic dac_bits_valid_o,
   output logic spi_mode_o,
   output logic [2:0] dac_ratio_o,
   output logic [2:0] adc_ratio_o,
   output logic ratio_error_o,
   output logic dac_osr_64_o,
   output logic adc_osr_64_o
);
   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   logic [8:0] pin_s;
   logic [8:0] ctl_s;
   logic rstn_s, sel_s, bs_s, dfr_s, afr_s;
   logic [3:0] din_s;
   logic role_s, dsp_s, ahalf_s;
   logic [2:0] dcode_s, acode_s;

   acrc_sync #(.W(9), .RST_VAL(9'h000)) u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i({control_reset_n_i, serial_select_i, bit_strobe_i,
                dac_word_frame_i, adc_word_frame_i, dac_serial_inputs_i}),
      .sync_o(pin_s)
   );

   // control values written without regard to the audio clocks
   acrc_sync #(.W(9), .RST_VAL({acrc_pkg::RST_ROLE, acrc_pkg::RST_RATIO,
      acrc_pkg::RST_RATIO, 2'h0})) u_ctl_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i({master_slave_select_i, dac_ratio_field_i, adc_ratio_field_i,
                dsp_format_i, adc_half_oversample_i}),
      .sync_o(ctl_s)
   );

   assign {rstn_s, sel_s, bs_s, dfr_s, afr_s, din_s} = pin_s;
   assign {role_s, dcode_s, acode_s, dsp_s, ahalf_s} = ctl_s;

   // ----------------------------------------------------------------
   // control port type latch
   // ----------------------------------------------------------------
   logic rstn_prev_ff;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rstn_prev_ff <= 1'b0;
      else
         rstn_prev_ff <= rstn_s;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         spi_mode_o <= acrc_pkg::RST_SPI;
      else if (rstn_s && !rstn_prev_ff)
         spi_mode_o <= sel_s;
   end

   // ----------------------------------------------------------------
   // role and pin direction
   // ----------------------------------------------------------------
   logic master_ff;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         master_ff <= acrc_pkg::RST_ROLE;
         bit_strobe_oe_o <= 1'b0;
         dac_word_frame_oe_o <= 1'b0;
         adc_word_frame_oe_o <= 1'b0;
      end
      else
      begin
         master_ff <= role_s;
         bit_strobe_oe_o <= role_s;
         dac_word_frame_oe_o <= role_s;
         adc_word_frame_oe_o <= role_s;
      end
   end

   // ----------------------------------------------------------------
   // slave ratio detection
   // ----------------------------------------------------------------
   logic dfr_prev_ff, afr_prev_ff;
   logic [2:0] det_dcode, det_acode;
   logic det_dlock, det_alock;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dfr_prev_ff <= 1'b0;
         afr_prev_ff <= 1'b0;
      end
      else
      begin
         dfr_prev_ff <= dfr_s;
         afr_prev_ff <= afr_s;
      end
   end

   acrc_ratio_det #(.LOW_OK(1'b1)) u_dac_det (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .frame_rise_i(dfr_s && !dfr_prev_ff && !master_ff),
      .code_o(det_dcode),
      .lock_o(det_dlock)
   );

   acrc_ratio_det #(.LOW_OK(1'b0)) u_adc_det (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .frame_rise_i(afr_s && !afr_prev_ff && !master_ff),
      .code_o(det_acode),
      .lock_o(det_alock)
   );

   // ----------------------------------------------------------------
   // effective ratios, oversampling, interface enable
   // ----------------------------------------------------------------
   logic [2:0] nxt_dcode, nxt_acode;
   logic iface_ok;

   always_comb
   begin
      nxt_dcode = master_ff ? dcode_s : det_dcode;
      nxt_acode = master_ff ? acode_s : det_acode;
      if (nxt_dcode > acrc_pkg::RATIO_LAST)
         nxt_dcode = acrc_pkg::RST_RATIO;
      if (acrc_pkg::low_ratio(nxt_acode) ||
          nxt_acode > acrc_pkg::RATIO_LAST)
         nxt_acode = acrc_pkg::ADC_RATIO_FALLBACK;
   end

   assign iface_ok = master_ff || (det_dlock && det_alock);

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dac_ratio_o <= acrc_pkg::RST_RATIO;
         adc_ratio_o <= acrc_pkg::RST_RATIO;
         ratio_error_o <= 1'b0;
         dac_osr_64_o <= 1'b0;
         adc_osr_64_o <= 1'b0;
      end
      else
      begin
         dac_ratio_o <= nxt_dcode;
         adc_ratio_o <= nxt_acode;
         ratio_error_o <= !iface_ok;
         dac_osr_64_o <= acrc_pkg::low_ratio(nxt_dcode);
         adc_osr_64_o <= ahalf_s;
      end
   end

   // ----------------------------------------------------------------
   // master frame and bit strobe generation
   // ----------------------------------------------------------------
   logic [9:0] dcnt_ff, acnt_ff, dlen, alen, nxt_dcnt, nxt_acnt;

   assign dlen = acrc_pkg::ratio_cycles(dac_ratio_o);
   assign alen = acrc_pkg::ratio_cycles(adc_ratio_o);
   assign nxt_dcnt = (dcnt_ff >= dlen - 10'h001) ? '0 : dcnt_ff + 10'h001;
   assign nxt_acnt = (acnt_ff >= alen - 10'h001) ? '0 : acnt_ff + 10'h001;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dcnt_ff <= '0;
         acnt_ff <= '0;
      end
      else if (!master_ff)
      begin
         dcnt_ff <= '0;
         acnt_ff <= '0;
      end
      else
      begin
         dcnt_ff <= nxt_dcnt;
         acnt_ff <= nxt_acnt;
      end
   end

   // frames high for the first half; change with bit strobe falling
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dac_word_frame_o <= 1'b0;
         adc_word_frame_o <= 1'b0;
      end
      else
      begin
         dac_word_frame_o <= master_ff && (nxt_dcnt < (dlen >> 1));
         adc_word_frame_o <= master_ff && (nxt_acnt < (alen >> 1));
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bit_strobe_o <= 1'b0;
         bit_strobe_bypass_o <= 1'b0;
      end
      else
      begin
         // dsp: pad routes the timebase itself onto the strobe pin
         bit_strobe_bypass_o <= master_ff && dsp_s;
         if (!master_ff)
            bit_strobe_o <= 1'b0;
         else if (acrc_pkg::low_ratio(dac_ratio_o))
            bit_strobe_o <= nxt_dcnt[0];
         else
            bit_strobe_o <= nxt_dcnt[1];
      end
   end

   // ----------------------------------------------------------------
   // serial data sampling and adc data output
   // ----------------------------------------------------------------
   logic bs_now, bs_prev_ff;

   assign bs_now = master_ff ? bit_strobe_o : bs_s;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         bs_prev_ff <= 1'b0;
      else
         bs_prev_ff <= bs_now;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dac_bits_o <= '0;
         dac_bits_valid_o <= 1'b0;
      end
      else
      begin
         dac_bits_valid_o <= 1'b0;
         if (iface_ok && bs_now && !bs_prev_ff)
         begin
            dac_bits_o <= din_s;
            dac_bits_valid_o <= 1'b1;
         end
      end
   end

   // held at the last value while the ratio check fails
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         adc_serial_data_o <= 1'b0;
      else if (iface_ok && !bs_now && bs_prev_ff)
         adc_serial_data_o <= adc_sample_bit_i;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_port_latch: assert property (
      (rstn_s && !rstn_prev_ff) |=> (spi_mode_o == $past(sel_s)))
      else $error("port type not caught at reset edge");
   chk_port_hold: assert property (
      !(rstn_s && !rstn_prev_ff) |=> $stable(spi_mode_o))
      else $error("port type changed without reset edge");
   chk_slave_dirs: assert property (
      !master_ff |-> !bit_strobe_oe_o && !dac_word_frame_oe_o &&
         !adc_word_frame_oe_o)
      else $error("slave mode drives frame pins");
   chk_master_dirs: assert property (
      master_ff |-> bit_strobe_oe_o && dac_word_frame_oe_o &&
         adc_word_frame_oe_o)
      else $error("master mode leaves pins undriven");
   chk_adc_no_low: assert property (
      !acrc_pkg::low_ratio(adc_ratio_o))
      else $error("adc path at dac-only ratio");
   chk_dac_osr: assert property (
      $changed(dac_ratio_o) |->
         dac_osr_64_o == acrc_pkg::low_ratio(dac_ratio_o))
      else $error("dac oversampling does not follow ratio");
   chk_adc_osr: assert property (
      ahalf_s |=> adc_osr_64_o)
      else $error("adc half oversample ignored");
   chk_half_rate: assert property (
      (master_ff && acrc_pkg::low_ratio(dac_ratio_o) && $stable(dac_ratio_o)
       && dcnt_ff != '0 && bit_strobe_o) |=> !bit_strobe_o)
      else $error("bit strobe not half rate");
   chk_quarter_rate: assert property (
      (master_ff && dac_ratio_o == acrc_pkg::RATIO_256 &&
       $past(dac_ratio_o) == acrc_pkg::RATIO_256 &&
       $past(dac_ratio_o, 2) == acrc_pkg::RATIO_256 &&
       $rose(bit_strobe_o)) |=> bit_strobe_o ##1 !bit_strobe_o)
      else $error("bit strobe not quarter rate");
   chk_hold_sample: assert property (
      ratio_error_o |-> !dac_bits_valid_o && $stable(adc_serial_data_o))
      else $error("data moved while ratio check failed");
   chk_dsp_bypass: assert property (
      (master_ff && dsp_s) |=> bit_strobe_bypass_o)
      else $error("dsp format without full rate strobe");

   cov_master_dsp: cover property (master_ff && dsp_s ##1 bit_strobe_bypass_o);
   cov_slave_lock: cover property (!master_ff && $fell(ratio_error_o));
   cov_slave_err: cover property (!master_ff && $rose(ratio_error_o));
   cov_port_latch: cover property (rstn_s && !rstn_prev_ff && !sel_s);
endmodule // acrc_top

// *** dv/acrc_dsp_model.sv ***
/*
 * Far-side audio controller model: drives the bit strobe, both word
 * frames and the four serial data lines while acting as timing master.
 * Assumes ref_clk_i is the shared master timebase.
 */
`timescale 1ns/1ps
module acrc_dsp_model (
   input wire logic ref_clk_i,
   input wire logic en_i,
   input wire logic [10:0] dac_period_i,
   input wire logic [10:0] adc_period_i,
   input wire logic [3:0] data_i,
   output logic bit_strobe_o,
   output logic dac_word_frame_o,
   output logic adc_word_frame_o,
   output logic [3:0] dac_serial_inputs_o
);
   logic [10:0] dac_cnt_ff;
   logic [10:0] adc_cnt_ff;

   // strobe stands still while idle
   initial bit_strobe_o = 1'b0;
   always #62.5 bit_strobe_o = en_i ? ~bit_strobe_o : 1'b0;

   // frames counted on the timebase itself
   always_ff @(posedge ref_clk_i)
   begin
      if (!en_i || dac_cnt_ff >= dac_period_i - 11'd1)
         dac_cnt_ff <= 11'd0;
      else
         dac_cnt_ff <= dac_cnt_ff + 11'd1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!en_i || adc_cnt_ff >= adc_period_i - 11'd1)
         adc_cnt_ff <= 11'd0;
      else
         adc_cnt_ff <= adc_cnt_ff + 11'd1;
   end

   assign dac_word_frame_o = en_i && (dac_cnt_ff < dac_period_i / 2);
   assign adc_word_frame_o = en_i && (adc_cnt_ff < adc_period_i / 2);
   // released lines show the inverse of data_i
   assign dac_serial_inputs_o = en_i ? data_i : ~data_i;
endmodule // acrc_dsp_model

// *** dv/acrc_top_bench.sv ***
/*
 * Self-checking bench for the clock ratio block: port type latch, master
 * frame and strobe generation, slave ratio detection and checking.
 * Assumes the far-side model file is compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
   fail_count++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
   end end
module acrc_top_bench;
   logic clk = 1'b0;
   logic rst, rstn, sel, ms, dsp, half, sbit, en;
   logic [2:0] dfield, afield, dac_r, adc_r;
   logic [10:0] dper, aper;
   logic [3:0] data, m_din, dbits;
   logic bs_o, bs_oe, byp, dwf_o, dwf_oe, awf_o, awf_oe, asd, dval;
   logic spi, err, dosr, aosr, m_bs, m_dwf, m_awf;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int n, k;
   int cyc_tab[6] = '{128, 192, 256, 384, 512, 768};
   logic [2:0] ea;

   always #2.5 clk = ~clk;

   acrc_top acrc_top_i (.ref_clk_i(clk), .rst_i(rst),
      .control_reset_n_i(rstn), .serial_select_i(sel),
      .master_slave_select_i(ms), .dac_ratio_field_i(dfield),
      .adc_ratio_field_i(afield), .dsp_format_i(dsp),
      .adc_half_oversample_i(half),
      .bit_strobe_i(bs_oe ? bs_o : m_bs),
      .dac_word_frame_i(dwf_oe ? dwf_o : m_dwf),
      .adc_word_frame_i(awf_oe ? awf_o : m_awf),
      .dac_serial_inputs_i(m_din), .adc_sample_bit_i(sbit),
      .bit_strobe_o(bs_o), .bit_strobe_oe_o(bs_oe),
      .bit_strobe_bypass_o(byp), .dac_word_frame_o(dwf_o),
      .dac_word_frame_oe_o(dwf_oe), .adc_word_frame_o(awf_o),
      .adc_word_frame_oe_o(awf_oe), .adc_serial_data_o(asd),
      .dac_bits_o(dbits), .dac_bits_valid_o(dval), .spi_mode_o(spi),
      .dac_ratio_o(dac_r), .adc_ratio_o(adc_r), .ratio_error_o(err),
      .dac_osr_64_o(dosr), .adc_osr_64_o(aosr));

   acrc_dsp_model acrc_dsp_model_i (.ref_clk_i(clk), .en_i(en),
      .dac_period_i(dper), .adc_period_i(aper), .data_i(data),
      .bit_strobe_o(m_bs), .dac_word_frame_o(m_dwf),
      .adc_word_frame_o(m_awf), .dac_serial_inputs_o(m_din));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic cyc(input int c);
      repeat (c)
      begin
         @(posedge clk);
         #1;
      end
   endtask

   function automatic logic pick(input int s);
      pick = (s == 0) ? dwf_o : (s == 1) ? awf_o : bs_o;
   endfunction

   // cycles between two rising edges of the picked output
   task automatic period(input int s, output int p);
      logic last;
      int j;
      j = 0;
      do
      begin
         last = pick(s);
         cyc(1);
         j++;
      end
      while (!(!last && pick(s)) && j < 2000);
      p = 0;
      do
      begin
         last = pick(s);
         cyc(1);
         p++;
      end
      while (!(!last && pick(s)) && p < 2000);
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst = 1'b1; rstn = 1'b0; sel = 1'b0; ms = 1'b0; dsp = 1'b0;
      half = 1'b0; sbit = 1'b1; en = 1'b0; dfield = 3'h2; afield = 3'h2;
      dper = 11'h180; aper = 11'h200; data = 4'h9;
      cyc(5);
      `CHK("spi_mode", 1'b1, spi)
      `CHK("dac_ratio", 3'h2, dac_r)
      rst = 1'b0;
      cyc(3);
      `CHK("strobe_oe", 1'b0, bs_oe)
      `CHK("ratio_error", 1'b1, err)
      rstn = 1'b1;
      cyc(5);
      `CHK("spi_mode", 1'b0, spi)
      sel = 1'b1;
      cyc(5);
      `CHK("spi_mode", 1'b0, spi)
      rstn = 1'b0;
      cyc(5);
      rstn = 1'b1;
      cyc(5);
      `CHK("spi_mode", 1'b1, spi)
      ms = 1'b1;
      for (int c = 0; c < 6; c++)
      begin
         dfield = c[2:0];
         afield = c[2:0];
         cyc(8);
         ea = (c < 2) ? 3'h2 : c[2:0];
         `CHK("dac_ratio", c[2:0], dac_r)
         `CHK("adc_ratio", ea, adc_r)
         `CHK("dac_osr64", c < 2, dosr)
         period(0, n);
         period(0, n);
         `CHK("dac_period", cyc_tab[c], n)
         period(1, n);
         period(1, n);
         `CHK("adc_period", cyc_tab[ea], n)
         period(2, n);
         `CHK("strobe_period", (c < 2) ? 2 : 4, n)
      end
      `CHK("strobe_oe", 1'b1, bs_oe)
      `CHK("dac_frame_oe", 1'b1, dwf_oe)
      `CHK("adc_frame_oe", 1'b1, awf_oe)
      `CHK("adc_osr64", 1'b0, aosr)
      `CHK("ratio_error", 1'b0, err)
      // dsp only at 768fs here
      dsp = 1'b1;
      half = 1'b1;
      cyc(5);
      `CHK("bypass", 1'b1, byp)
      `CHK("adc_osr64", 1'b1, aosr)
      dsp = 1'b0;
      half = 1'b0;
      cyc(5);
      `CHK("bypass", 1'b0, byp)
      ms = 1'b0;
      en = 1'b1;
      cyc(3000);
      `CHK("dac_frame_oe", 1'b0, dwf_oe)
      `CHK("ratio_error", 1'b0, err)
      `CHK("dac_ratio", 3'h3, dac_r)
      `CHK("adc_ratio", 3'h4, adc_r)
      dper = 11'd414;
      cyc(2000);
      `CHK("ratio_error", 1'b0, err)
      k = 0;
      while (dval !== 1'b1 && k < 300)
      begin
         cyc(1);
         k++;
      end
      `CHK("dac_valid", 1'b1, dval)
      `CHK("dac_bits", 4'h9, dbits)
      `CHK("adc_data", 1'b1, asd)
      dper = 11'd424;
      cyc(2000);
      `CHK("ratio_error", 1'b1, err)
      sbit = 1'b0;
      cyc(200);
      `CHK("adc_data", 1'b1, asd)
      tally_and_finish();
   end
endmodule // acrc_top_bench
